/* rtl/mac_if_pkg.sv */
package mac_if_pkg;
  // system clock rate and the link rates made from it
  localparam int unsigned CLK_SYS_MHZ   = 100;
  localparam int unsigned MII100_KHZ    = 25000;
  localparam int unsigned MII10_KHZ     = 2500;
  localparam int unsigned RMII_REF_KHZ  = 50000;

  // half periods of the generated link clock, in system cycles
  localparam logic [5:0] HALF_MII100 = 6'(CLK_SYS_MHZ * 1000 / (2 * MII100_KHZ));
  localparam logic [5:0] HALF_MII10  = 6'(CLK_SYS_MHZ * 1000 / (2 * MII10_KHZ));
  localparam logic [5:0] HALF_RMII   = 6'(CLK_SYS_MHZ * 1000 / (2 * RMII_REF_KHZ));

  // rmii at 10 mb/s repeats each dibit over this many reference cycles
  localparam logic [3:0] RMII10_REPEAT = 4'ha;

  // heartbeat (sqe test) pulse width
  localparam int unsigned SQE_TIME_NS = 1000;
  localparam logic [7:0]  SQE_CYCLES  = 8'(SQE_TIME_NS * CLK_SYS_MHZ / 1000);

  // dibit sent in place of data on a receive error
  localparam logic [1:0] RMII_ERR_DIBIT = 2'h1;

  // data widths
  localparam int unsigned NIB_W   = 4;
  localparam int unsigned ENTRY_W = 5;

  // interface mode select
  typedef enum logic [1:0] {
    MODE_MII         = 2'b00,
    MODE_RMII_SLAVE  = 2'b01,
    MODE_RMII_MASTER = 2'b10
  } if_mode_t;
endpackage

/* rtl/skid_buf2.sv */
`timescale 1ns/1ps
// two-entry buffer with valid/ready on both sides
module skid_buf2 #(
  parameter int unsigned W = 5
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  logic [W-1:0] mem_q [2];   // two storage slots
  logic         wr_ptr_q;    // next slot to fill
  logic         rd_ptr_q;    // next slot to drain
  logic [1:0]   cnt_q;       // entries held
  logic         push;
  logic         pop;
  logic [1:0]   cnt_d;       // entries held after this edge
  logic         ready_q;     // room flag, registered for the pin

  // full refuses, empty shows no valid
  assign o_in_ready  = ready_q;
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data  = mem_q[rd_ptr_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  // next occupancy; simultaneous push and pop keeps the count
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
      ready_q  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q   <= cnt_d;
      // ready leaves a flop fed from the next count, so the buffer refuses from the edge that fills it
      ready_q <= (cnt_d != 2'h2);
    end
  end
endmodule

/* rtl/mac_data_if.sv */
`timescale 1ns/1ps
module mac_data_if (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // static configuration pins
  // only changed while held in reset
  input  wire logic [1:0] i_mode,
  input  wire logic       i_speed_100,
  input  wire logic       i_full_duplex,
  input  wire logic       i_heartbeat_en,
  // mac facing pins
  // transmit pins are inputs, receive and clock pins outputs
  // txd[3:2] and rxd[3:2] idle in rmii
  input  wire logic       i_tx_en,
  input  wire logic [3:0] i_txd,
  output logic            o_tx_clk,
  output logic            o_rx_clk,
  output logic            o_rx_dv,
  output logic            o_rx_er,
  output logic [3:0]      o_rxd,
  output logic            o_crs,
  output logic            o_col,
  // line side receive stream
  // one word taken per valid and ready edge
  input  wire logic       i_line_carrier,
  input  wire logic       i_line_valid,
  input  wire logic [3:0] i_line_data,
  input  wire logic       i_line_err,
  output logic            o_line_ready,
  // line side transmit stream
  output logic            o_line_tx_valid,
  output logic [3:0]      o_line_tx_data,
  output logic            o_line_tx_en
);

  // both rmii flavours share the dibit path
  // mode decoding, called once to make the rmii signal
  function automatic logic is_rmii(input logic [1:0] mode);
    is_rmii = (mode == mac_if_pkg::MODE_RMII_SLAVE) ||
              (mode == mac_if_pkg::MODE_RMII_MASTER);
  endfunction

  // master and mii both own the clock pins
  function automatic logic drives_clk(input logic [1:0] mode);
    // slave rmii leaves both clock pins idle
    drives_clk = (mode != mac_if_pkg::MODE_RMII_SLAVE);
  endfunction

  // link clock and slot timing
  logic       rmii;          // rmii mode of either kind
  logic [5:0] half_sel;      // half period for current mode
  logic [5:0] div_cnt_q;     // clock divider count
  logic       link_clk_q;    // internal link clock phase
  logic       div_wrap;      // half period elapsed
  logic       tick_rise;     // link clock about to rise
  logic [3:0] rep_cnt_q;     // rmii 10 mb/s repeat count
  logic       data_en;       // one data transfer slot

  // transmit assembly
  logic       tx_phase_q;    // rmii transmit dibit phase
  logic [1:0] tx_low_q;      // first dibit of a nibble
  logic       tx_act_q;      // mac transmit activity seen

  // receive path, carrier and collision
  logic       buf_valid;     // receive buffer has a nibble
  logic [4:0] buf_data;      // {err, nibble}
  logic       buf_ready;     // drain request
  logic       rx_phase_q;    // rmii receive dibit phase
  logic [1:0] rx_dibit;      // dibit chosen for this slot
  logic [7:0] sqe_cnt_q;     // heartbeat remaining cycles
  logic       col_d;

  // decoded once, read by every process except the divider, clock pin, tx activity, dibit select and col pin ones
  // code 11 falls back to mii with the clocks driven
  assign rmii = is_rmii(i_mode);

  // divider half period, illegal mode code falls back to mii timing
  always_comb begin
    if (rmii) begin
      // 50 mhz reference: toggle every cycle
      half_sel = mac_if_pkg::HALF_RMII;
    end else if (i_speed_100) begin
      // 25 mhz nibble clock
      half_sel = mac_if_pkg::HALF_MII100;
    end else begin
      // 2.5 mhz nibble clock
      half_sel = mac_if_pkg::HALF_MII10;
    end
  end

  // >= so a mode change mid count cannot overrun
  // tick_rise marks the slot edge, where the pins go high
  assign div_wrap  = (div_cnt_q >= half_sel - 6'h01);
  assign tick_rise = div_wrap & ~link_clk_q;

  // one divider serves both pins and the slot enables
  // link clock divider
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // counter and phase start low
      div_cnt_q  <= 6'h00;
      link_clk_q <= 1'b0;
    end else if (div_wrap) begin
      // half period done: flip the phase
      div_cnt_q  <= 6'h00;
      link_clk_q <= ~link_clk_q;
    end else begin
      // still counting
      div_cnt_q  <= div_cnt_q + 6'h01;
    end
  end

  // registered so the pins cannot glitch on the mode decode
  // clock pins follow the divider
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // both pins low in reset
      o_tx_clk <= 1'b0;
      o_rx_clk <= 1'b0;
    end else if (!drives_clk(i_mode)) begin
      o_tx_clk <= 1'b0;
      o_rx_clk <= 1'b0;
    end else begin
      // next phase, so the pin rises on the slot edge
      // rx clock from same divider
      o_tx_clk <= div_wrap ? ~link_clk_q : link_clk_q;
      o_rx_clk <= div_wrap ? ~link_clk_q : link_clk_q;
    end
  end

  // rmii at 10 mb/s takes one slot in every ten reference cycles
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // count from slot zero
      rep_cnt_q <= 4'h0;
    end else if (!rmii || i_speed_100) begin
      // full rate: every rising edge is a slot
      rep_cnt_q <= 4'h0;
    end else if (tick_rise) begin
      // 10 mb/s on a 50 mhz clock needs one slot in ten
      // wrap after the last repeat
      rep_cnt_q <= (rep_cnt_q == mac_if_pkg::RMII10_REPEAT - 4'h1) ? 4'h0
                                                                  : rep_cnt_q + 4'h1;
    end
  end

  // one enable pulse per data transfer
  assign data_en = tick_rise & (rep_cnt_q == 4'h0);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // nothing assembled after reset
      o_line_tx_valid <= 1'b0;
      o_line_tx_data  <= 4'h0;
      tx_phase_q      <= 1'b0;
      tx_low_q        <= 2'h0;
    end else begin
      // valid is a one cycle pulse by default
      o_line_tx_valid <= 1'b0;
      if (data_en) begin
        if (!i_tx_en) begin
          // idle slot: restart on the low dibit; an odd dibit is lost
          tx_phase_q <= 1'b0;
        end else if (!rmii) begin
          o_line_tx_valid <= 1'b1;
          o_line_tx_data  <= i_txd;
        end else if (!tx_phase_q) begin
          // first dibit is the low half
          tx_low_q   <= i_txd[1:0];
          tx_phase_q <= 1'b1;
        end else begin
          // second dibit completes the nibble
          o_line_tx_valid <= 1'b1;
          o_line_tx_data  <= {i_txd[1:0], tx_low_q};
          tx_phase_q      <= 1'b0;
        end
      end
    end
  end

  // transmit activity, used by collision and heartbeat
  // sampled at slots only, like the data
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // idle after reset
      tx_act_q     <= 1'b0;
      o_line_tx_en <= 1'b0;
    end else if (data_en) begin
      // follow tx_en once per slot
      tx_act_q     <= i_tx_en;
      o_line_tx_en <= i_tx_en;
    end
  end

  // receive words wait here; the mac slot rate is the drain side
  // depth two absorbs one slot of stall; beyond that the line side waits
  // error flag rides in the top bit of each entry
  skid_buf2 #(
    .W (mac_if_pkg::ENTRY_W)
  ) u_rx_buf (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_line_valid),
    .o_in_ready  (o_line_ready),
    .i_in_data   ({i_line_err, i_line_data}),
    .o_out_valid (buf_valid),
    .i_out_ready (buf_ready),
    .o_out_data  (buf_data)
  );

  // mii pops each slot, rmii after the second dibit
  // rmii keeps the word until both dibits are out
  assign buf_ready = data_en & buf_valid & (!rmii | rx_phase_q);

  // a mac that ignores rx_er still fails the frame check
  // error replaces the dibit
  always_comb begin
    if (buf_data[4]) begin
      // bad word: both dibits become the error code
      rx_dibit = mac_if_pkg::RMII_ERR_DIBIT;
    end else if (rx_phase_q) begin
      // upper dibit on the second slot
      rx_dibit = buf_data[3:2];
    end else begin
      // lower dibit first
      rx_dibit = buf_data[1:0];
    end
  end

  // receive data, valid and error outputs
  // rmii uses the low two bits, the upper pair stays zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // quiet receive pins after reset
      o_rxd      <= 4'h0;
      o_rx_dv    <= 1'b0;
      o_rx_er    <= 1'b0;
      rx_phase_q <= 1'b0;
    end else if (data_en) begin
      // outputs stand until the next slot
      if (!buf_valid) begin
        // idle slot: nothing to deliver
        o_rxd      <= 4'h0;
        o_rx_dv    <= 1'b0;
        o_rx_er    <= 1'b0;
        rx_phase_q <= 1'b0;
      end else if (!rmii) begin
        o_rxd   <= buf_data[3:0];
        o_rx_dv <= 1'b1;
        // limitation: no error flag at 10 mb/s
        // error only at 100
        o_rx_er <= buf_data[4] & i_speed_100;
      end else begin
        o_rxd      <= {2'h0, rx_dibit};
        o_rx_dv    <= 1'b1;
        o_rx_er    <= buf_data[4] & i_speed_100;
        // phase flips only while a word is out
        rx_phase_q <= ~rx_phase_q;
      end
    end
  end

  // carrier sense pin
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // no carrier after reset
      o_crs <= 1'b0;
    end else if (!rmii) begin
      // mii: follows the line every cycle
      // busy medium raises crs
      o_crs <= i_line_carrier;
    end else if (data_en) begin
      // limitation: no toggling of crs_dv at carrier end
      // carrier or pending data
      o_crs <= i_line_carrier | buf_valid;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // no heartbeat pending
      sqe_cnt_q <= 8'h00;
    end else if (data_en && tx_act_q && !i_tx_en && !rmii && !i_speed_100 &&
                 !i_full_duplex && i_heartbeat_en) begin
      // end of a 10 mb/s half duplex frame; load wins over the count
      sqe_cnt_q <= mac_if_pkg::SQE_CYCLES;
    end else if (sqe_cnt_q != 8'h00) begin
      // count the pulse down to zero
      sqe_cnt_q <= sqe_cnt_q - 8'h01;
    end
  end

  // collision term; rmii has no col pin so it is held low
  always_comb begin
    // default: no collision
    col_d = 1'b0;
    if (!rmii && !i_full_duplex) begin
      // heartbeat shares the col pin
      // overlap of tx and rx
      col_d = (tx_act_q & i_line_carrier) | (sqe_cnt_q != 8'h00);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // col low during reset
      o_col <= 1'b0;
    end else begin
      // registered so col comes straight from a flop
      // rmii mac detects its own
      o_col <= col_d;
    end
  end
endmodule

/* tb/mac_data_if_chk.sv */
`timescale 1ns/1ps
// pin level checks for the mac data interface
module mac_data_if_chk (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic [1:0] i_mode,
  input wire logic       i_speed_100,
  input wire logic       i_full_duplex,
  input wire logic       i_heartbeat_en,
  input wire logic       i_line_carrier,
  input wire logic       o_tx_clk,
  input wire logic       o_rx_clk,
  input wire logic       o_rx_er,
  input wire logic [3:0] o_rxd,
  input wire logic       o_col,
  input wire logic       o_crs,
  input wire logic       o_line_tx_valid
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic mii;  // plain mii selected
  logic rmii; // either rmii mode
  assign mii  = (i_mode == 2'h0);
  assign rmii = (i_mode == 2'h1) || (i_mode == 2'h2);

  clk_pair_a: assert property (o_rx_clk == o_tx_clk)
    else $error("rx clock differs from tx clock");
  slave_quiet_a: assert property (i_mode == 2'h1 |-> !o_tx_clk && !o_rx_clk)
    else $error("clock driven in rmii slave");
  mii_fast_a: assert property (mii && i_speed_100 && $rose(o_tx_clk)
    |-> o_tx_clk[*2] ##1 !o_tx_clk[*2] ##1 o_tx_clk) else $error("mii clock not 25 mhz");
  master_clk_a: assert property (i_mode == 2'h2 && $rose(o_tx_clk)
    |=> !o_tx_clk ##1 o_tx_clk) else $error("master clock not 50 mhz");
  duplex_col_a: assert property (i_full_duplex |-> !o_col)
    else $error("col high in full duplex");
  crs_follow_a: assert property (mii |=> o_crs == $past(i_line_carrier))
    else $error("crs does not follow carrier");
  quiet_col_a: assert property (mii && !i_heartbeat_en && !i_line_carrier |=> !o_col)
    else $error("col without receive activity");
  rmii_col_a: assert property (rmii |-> !o_col)
    else $error("col driven in rmii");
  slow_er_a: assert property (!i_speed_100 |-> !o_rx_er)
    else $error("rx error at 10 mb/s");
  rmii_hi_a: assert property (rmii |-> o_rxd[3:2] == 2'h0)
    else $error("upper rx bits driven in rmii");
  cover property (mii && $rose(o_col) && !i_line_carrier);
  cover property (o_rx_er);
  cover property (o_line_tx_valid);
endmodule
bind mac_data_if mac_data_if_chk chk (.*);

/* tb/mac_model.sv */
`timescale 1ns/1ps
// mac transmit side, timed from the tx clock pin
module mac_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_tx_clk,
  input  wire logic       i_rmii,
  input  wire logic       i_go,
  input  wire logic [3:0] i_data,
  output logic            o_tx_en,
  output logic [3:0]      o_txd
);
  logic clk_q; // last tx clock level
  logic hi_q;  // rmii: upper dibit due next
  // launch one edge after the pin rose, so data holds a full period
  // tx clock launch framing
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_q   <= 1'b0;
      hi_q    <= 1'b0;
      o_tx_en <= 1'b0;
      o_txd   <= 4'h0;
    end else begin
      clk_q <= i_tx_clk;
      if (i_tx_clk && !clk_q) begin
        // a pending upper dibit keeps the nibble whole
        o_tx_en <= i_go || hi_q;
        hi_q    <= i_rmii && i_go && !hi_q;
        if (!(i_go || hi_q)) begin
          o_txd <= ~o_txd; // idle lines wander, never a stale copy
        end else if (i_rmii) begin
          o_txd <= {2'h0, hi_q ? i_data[3:2] : i_data[1:0]};
        end else begin
          o_txd <= i_data;
        end
      end
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
// bench for mac_data_if: mac model on the pins, line stream from here
module testbench;
  logic       i_clk_sys, i_rst_n, i_speed_100, i_full_duplex, i_heartbeat_en;
  logic [1:0] i_mode;
  logic       i_tx_en, i_line_carrier, i_line_valid, i_line_err, go;
  logic [3:0] i_txd, i_line_data, gdata, o_rxd, o_line_tx_data;
  logic       o_tx_clk, o_rx_clk, o_rx_dv, o_rx_er, o_crs, o_col, o_line_ready;
  logic       o_line_tx_valid, o_line_tx_en;
  int         n_fail, n_compared, hold;
  mac_data_if uut (.*);
  mac_model mac (.i_clk_sys, .i_rst_n, .i_tx_clk(o_tx_clk), .i_rmii(i_mode != 2'h0),
                 .i_go(go), .i_data(gdata), .o_tx_en(i_tx_en), .o_txd(i_txd));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task check(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // sample just after the edge, once its updates have landed
  task tick;
    @(posedge i_clk_sys);
    #1;
  endtask
  // static config only changes under reset
  task setup(logic [4:0] cfg);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    {i_mode, i_speed_100, i_full_duplex, i_heartbeat_en} <= cfg;
    {go, i_line_carrier, i_line_valid} <= 3'h0;
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    tick;
  endtask
  // cycles from one rise of the tx clock to the next
  task clk_period(logic [7:0] exp);
    int n;
    n = 0;
    for (int i = 0; i < 99 && o_tx_clk !== 1'b1; i++) tick;
    do begin
      tick;
      n++;
    end while (o_tx_clk === 1'b1 && n < 99);
    do begin
      tick;
      n++;
    end while (o_tx_clk !== 1'b1 && n < 99);
    check("tx clock period", 8'(n), exp);
  endtask
  task tx_take(logic [3:0] exp);
    tick;
    for (int i = 0; i < 200 && o_line_tx_valid !== 1'b1; i++) tick;
    check("tx data", o_line_tx_data, exp);
    check("tx enable", o_line_tx_en, 1'b1);
  endtask
  // word held until the buffer takes it
  task push(logic [3:0] w, logic e);
    @(posedge i_clk_sys);
    {i_line_valid, i_line_data, i_line_err} <= {1'b1, w, e};
    do @(posedge i_clk_sys); while (o_line_ready !== 1'b1);
    {i_line_valid, i_line_data, i_line_err} <= {1'b0, ~w, 1'b0};
  endtask
  task wait_dv;
    for (int i = 0; i < 200 && o_rx_dv !== 1'b1; i++) tick;
  endtask
  task t_mii100;
    setup(5'h04);
    clk_period(8'h04);
    @(posedge i_clk_sys);
    {go, gdata} <= 5'h1a;
    tx_take(4'ha);
    tx_take(4'ha);
    @(posedge i_clk_sys);
    i_line_carrier <= 1'b1;
    repeat (3) tick;
    check("collision", o_col, 1'b1);
    check("carrier", o_crs, 1'b1);
    push(4'h9, 1'b1);
    wait_dv;
    check("rx word", o_rxd, 4'h9);
    check("rx error", o_rx_er, 1'b1);
    $display("mii 100 test done");
  endtask
  // three quick words against a slow drain: the third is refused a while
  task t_mii10_fill;
    setup(5'h00);
    clk_period(8'h28);
    hold = 0;
    fork
      begin
        push(4'h5, 1'b0);
        push(4'h6, 1'b1);
        push(4'h7, 1'b0);
      end
    join_none
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 300 && o_rxd !== 4'(5 + k); i++) begin
        tick;
        hold += (o_line_ready === 1'b0);
      end
      check("rx word", o_rxd, 4'(5 + k));
      check("rx valid", o_rx_dv, 1'b1);
      check("rx error", o_rx_er, 1'b0);
    end
    check("buffer refused", 8'(hold > 0), 8'h01);
    $display("mii 10 buffer test done");
  endtask
  // heartbeat length in cycles after one short transmission
  task t_hb(logic [4:0] cfg, logic [7:0] exp);
    setup(cfg);
    @(posedge i_clk_sys);
    {go, gdata} <= 5'h13;
    tx_take(4'h3);
    @(posedge i_clk_sys);
    go <= 1'b0;
    hold = 0;
    repeat (300) begin
      tick;
      hold += (o_col === 1'b1);
    end
    check("heartbeat cycles", 8'(hold), exp);
    $display("heartbeat test done");
  endtask
  task t_rmii_master;
    setup(5'h14);
    clk_period(8'h02);
    @(posedge i_clk_sys);
    {go, gdata} <= 5'h16;
    tx_take(4'h6);
    tx_take(4'h6);
    @(posedge i_clk_sys);
    go <= 1'b0;
    fork
      begin
        push(4'h6, 1'b0);
        push(4'h9, 1'b1);
      end
    join_none
    wait_dv;
    // good word low dibit first, then the bad word as two error dibits
    for (int k = 0; k < 4; k++) begin
      check("rmii dibit", o_rxd, 4'((k == 0) ? 2 : 1));
      check("rmii error", o_rx_er, 1'(k > 1));
      check("rmii valid", o_rx_dv, 1'b1);
      check("crs_dv busy", o_crs, 1'b1);
      repeat (2) tick;
    end
    check("crs_dv idle", o_crs, 1'b0);
    check("rmii valid idle", o_rx_dv, 1'b0);
    $display("rmii master test done");
  endtask
  task t_slave;
    setup(5'h0c);
    repeat (20) tick;
    check("slave tx clock", o_tx_clk, 1'b0);
    check("slave rx clock", o_rx_clk, 1'b0);
    $display("rmii slave test done");
  endtask
  initial begin
    i_rst_n = 1'b0;
    {i_mode, i_speed_100, i_full_duplex, i_heartbeat_en} = 5'h00;
    {go, gdata, i_line_carrier, i_line_valid, i_line_data, i_line_err} = 12'h000;
    n_fail = 0;
    n_compared = 0;
    t_mii100;
    t_mii10_fill;
    t_hb(5'h01, 8'h64);
    t_hb(5'h03, 8'h00);
    t_rmii_master;
    t_slave;
    wrap_up;
  end
  // all tests need under two thousand cycles; ten thousand means a hang
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
endmodule
